// [verilog/power_seq_regs.vh]
// Constants for the regulator and reset sequencer
// ==========================================================
// Operation
// RULE1: Regulators are enabled when either power request is high.
// RULE2: A high wireless request releases the wireless section from reset.
// RULE3: A low wireless request holds the wireless section in reset.
// RULE4: With both requests low the regulators are disabled.
// RULE5: A low application request holds the application CPU in reset.
// RULE6: The host waits at least 10 ms with both requests low before raising one.
// RULE7: After power-on the device holds itself in reset at most 110 ms.
// RULE8: The host may stretch any sequencing interval beyond its minimum.
// RULE9: Both request pins pass a two-stage synchroniser before use.
// ==========================================================
`ifndef POWER_SEQ_REGS_VH
`define POWER_SEQ_REGS_VH

// Hold and off times in cycles of the 50 MHz clock
// Power-on hold, 110 ms
`define POR_HOLD_CYCLES 23'h53ec60
// Least off time, 10 ms
`define DISCHARGE_CYCLES 23'h07a120

// Counter width and steps
`define CNT_W 23
`define CNT_ZERO 23'h0
`define CNT_STEP 23'h1

// Request positions and synchroniser stages
`define NUM_REQ 2
`define REQ_WLAN 0
`define REQ_APPS 1
`define SYNC_FIRST 0
`define SYNC_LAST 1

// Reset levels
`define SYNC_RST 2'h0
`define SEC_RESET_ON 1'h1
`define DEV_RESET_ON 1'h1
`define REG_ENABLE_RST 1'h0
`define DONE_RST 1'h0

// Sequencer states
`define ST_POR 2'h0
`define ST_RUN 2'h1

`endif

// [verilog/regulator_and_reset_control.v]
// Power request decoder with power-on reset hold
`timescale 1ns/1ps
`include "power_seq_regs.vh"

module regulator_and_reset_control #(
   parameter [22:0] POR_HOLD_CYCLES = `POR_HOLD_CYCLES,
   parameter [22:0] DISCHARGE_CYCLES = `DISCHARGE_CYCLES
) (
   // Clock and reset
   input wire mclk_in,
   input wire rst_in,
   // Power request pins
   input wire wlan_power_request_in,
   input wire apps_power_request_in,
   // Regulator and section controls
   output reg regulator_enable_out,
   output reg wlan_reset_out,
   output reg apps_reset_out,
   output reg device_reset_out,
   // Off-time spacing status
   output reg discharge_done_out
);

   // ==========================================================
   // Local constants

   // Sequencer states
   localparam ST_POR = `ST_POR;
   localparam ST_RUN = `ST_RUN;

   // Request positions and synchroniser stages
   localparam NUM_REQ = `NUM_REQ;
   localparam REQ_WLAN = `REQ_WLAN;
   localparam REQ_APPS = `REQ_APPS;
   localparam SYNC_FIRST = `SYNC_FIRST;
   localparam SYNC_LAST = `SYNC_LAST;

   // ==========================================================
   // Section reset decode
   // A section leaves reset only with its request and the hold over
   function section_reset;
      input request;
      input released;
      begin
         section_reset = ~(request & released);
      end
   endfunction

   // ==========================================================
   // Request synchronisers
   wire [NUM_REQ-1:0] req_pin;
   wire [NUM_REQ-1:0] req_sync;
   wire wlan_req;
   wire apps_req;

   assign req_pin[REQ_WLAN] = wlan_power_request_in;
   assign req_pin[REQ_APPS] = apps_power_request_in;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_REQ; gi = gi + 1) begin : g_sync
         reg [1:0] sync_reg;

         // RULE9: two-stage synchroniser
         always @(posedge mclk_in or posedge rst_in) begin
            if (rst_in) begin
               sync_reg <= `SYNC_RST;
            end else begin
               sync_reg <= {sync_reg[SYNC_FIRST], req_pin[gi]};
            end
         end

         // Only the second stage is read
         assign req_sync[gi] = sync_reg[SYNC_LAST];
      end
   endgenerate

   assign wlan_req = req_sync[REQ_WLAN];
   assign apps_req = req_sync[REQ_APPS];

   // ==========================================================
   // Power-on hold
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [`CNT_W-1:0] por_cnt_reg;
   reg [`CNT_W-1:0] por_cnt_next;
   wire por_last;
   wire released_next;

   assign por_last = (por_cnt_reg >= POR_HOLD_CYCLES - `CNT_STEP);

   always @* begin
      state_next = state_reg;
      por_cnt_next = por_cnt_reg;
      case (state_reg)
         ST_POR: begin
            // RULE7: bounded reset hold
            if (por_last) begin
               state_next = ST_RUN;
            end else begin
               por_cnt_next = por_cnt_reg + `CNT_STEP;
            end
         end
         ST_RUN: begin
            state_next = ST_RUN;
         end
         default: begin
            state_next = ST_POR;
            por_cnt_next = `CNT_ZERO;
         end
      endcase
   end

   always @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= ST_POR;
         por_cnt_reg <= `CNT_ZERO;
      end else begin
         state_reg <= state_next;
         por_cnt_reg <= por_cnt_next;
      end
   end

   // Outputs use the next state, keeping the hold inside its limit
   assign released_next = (state_next == ST_RUN);

   // ==========================================================
   // Off-time counter
   reg [`CNT_W-1:0] off_cnt_reg;
   reg [`CNT_W-1:0] off_cnt_next;
   wire any_req;
   wire off_full_next;

   assign any_req = wlan_req | apps_req;

   // Saturates at the limit while both requests stay low
   always @* begin
      off_cnt_next = off_cnt_reg;
      if (any_req) begin
         off_cnt_next = `CNT_ZERO;
      end else if (off_cnt_reg < DISCHARGE_CYCLES) begin
         off_cnt_next = off_cnt_reg + `CNT_STEP;
      end
   end

   always @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         off_cnt_reg <= `CNT_ZERO;
      end else begin
         off_cnt_reg <= off_cnt_next;
      end
   end

   // Status only; spacing the requests is up to the host
   assign off_full_next = (off_cnt_next >= DISCHARGE_CYCLES);

   // ==========================================================
   // Next output values
   wire reg_enable_next;
   wire wlan_reset_next;
   wire apps_reset_next;
   wire device_reset_next;

   // Both section resets share one decode
   assign reg_enable_next = any_req;
   assign wlan_reset_next = section_reset(wlan_req, released_next);
   assign apps_reset_next = section_reset(apps_req, released_next);
   assign device_reset_next = ~released_next;

   // ==========================================================
   // Regulator enable
   // RULE1: OR of requests
   // RULE4: both low disables
   always @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         regulator_enable_out <= `REG_ENABLE_RST;
      end else begin
         regulator_enable_out <= reg_enable_next;
      end
   end

   // ==========================================================
   // Wireless section reset
   // RULE2: release on request
   // RULE3: hold while low
   always @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         wlan_reset_out <= `SEC_RESET_ON;
      end else begin
         wlan_reset_out <= wlan_reset_next;
      end
   end

   // ==========================================================
   // Application section reset
   // RULE5: held while low
   always @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         apps_reset_out <= `SEC_RESET_ON;
      end else begin
         apps_reset_out <= apps_reset_next;
      end
   end

   // ==========================================================
   // Device power-on reset
   // RULE7: hold then release
   always @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         device_reset_out <= `DEV_RESET_ON;
      end else begin
         device_reset_out <= device_reset_next;
      end
   end

   // ==========================================================
   // Off-time status
   // RULE6: spacing observed
   always @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         discharge_done_out <= `DONE_RST;
      end else begin
         discharge_done_out <= off_full_next;
      end
   end

endmodule // regulator_and_reset_control

// [sim/regulator_and_reset_control_asserts.sv]
// Sequencer checker
`timescale 1ns/1ps
module regulator_and_reset_control_asserts (
   // Clock and reset
   input logic mclk_in,
   input logic rst_in,
   // Power request pins
   input logic wlan_power_request_in,
   input logic apps_power_request_in,
   // Outputs watched
   input logic regulator_enable_out,
   input logic wlan_reset_out,
   input logic apps_reset_out,
   input logic device_reset_out,
   input logic discharge_done_out
);
   logic [2:0] w, a, r;
   always @(posedge mclk_in) begin
      w <= {w[1:0], wlan_power_request_in};
      a <= {a[1:0], apps_power_request_in};
      r <= {r[1:0], rst_in};
   end
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   a_reg_or: assert property (
      !r[2] |-> regulator_enable_out == (w[2] | a[2])) else $error("reg");
   a_reg_off: assert property (
      !r[2] && !w[2] && !a[2] |-> !regulator_enable_out) else $error("off");
   a_wlan_rst: assert property (
      !r[2] && !$past(device_reset_out, 2) |-> wlan_reset_out == !w[2])
      else $error("wlan");
   a_apps_rst: assert property (
      !r[2] && !$past(device_reset_out, 2) |-> apps_reset_out == !a[2])
      else $error("apps");
   a_por_hold: assert property (
      device_reset_out |-> wlan_reset_out && apps_reset_out) else $error("hold");
   a_por_once: assert property (
      !device_reset_out |=> !device_reset_out) else $error("por");
   a_dis_off: assert property (
      discharge_done_out |-> !regulator_enable_out) else $error("dis");
endmodule // regulator_and_reset_control_asserts

// [sim/power_host_model.sv]
// Host model driving the power request pins
`timescale 1ns/1ps
module power_host_model #(parameter int GAP = 10) (
   input logic mclk_in,
   output logic wl_out,
   output logic ap_out
);
   initial {wl_out, ap_out} = 2'h0;
   task drive(input logic w, input logic a, input int hold);
      @(posedge mclk_in);
      #1 {wl_out, ap_out} = {w, a};
      repeat (hold + ((w | a) ? 0 : GAP)) @(posedge mclk_in);
   endtask
endmodule // power_host_model

// [sim/regulator_and_reset_control_tb_top.sv]
// Bench for the regulator and reset sequencer
`timescale 1ns/1ps
module regulator_and_reset_control_tb_top;
   localparam int POR = 20;
   localparam int DIS = 10;
   logic mclk_in = 0, rst_in = 1, wl, ap, en, wr, ar, dr, dd;
   logic [2:0] wh = 0, ah = 0;
   int cyc = 0, off = 0, n_mismatch = 0, comparisons = 0;
   always #10 mclk_in = ~mclk_in;
   power_host_model #(.GAP(DIS)) i_host (.mclk_in(mclk_in), .wl_out(wl),
      .ap_out(ap));
   regulator_and_reset_control #(.POR_HOLD_CYCLES(23'(POR)),
      .DISCHARGE_CYCLES(23'(DIS))) i_dut (.mclk_in(mclk_in),
      .rst_in(rst_in),
      .wlan_power_request_in(wl), .apps_power_request_in(ap),
      .regulator_enable_out(en), .wlan_reset_out(wr), .apps_reset_out(ar),
      .device_reset_out(dr), .discharge_done_out(dd));
   task check(input string n, input logic e, input logic s);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error %s expected %b seen %b", n, e, s);
      end
   endtask
   task report_and_stop;
      if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Reference model: pin history cleared in reset like the synchronisers
   always @(posedge mclk_in) begin
      wh <= rst_in ? 3'h0 : {wh[1:0], wl};
      ah <= rst_in ? 3'h0 : {ah[1:0], ap};
      cyc <= rst_in ? 0 : cyc + 1;
      off <= (rst_in || wh[1] || ah[1]) ? 0 : (off < DIS ? off + 1 : off);
   end
   always @(negedge mclk_in) if (!rst_in) begin
      check("device_reset", cyc < POR, dr);
      if (cyc > 3) check("regulator", wh[2] | ah[2], en);
      if (cyc > POR + 2) check("wlan_reset", !wh[2], wr);
      if (cyc > POR + 2) check("apps_reset", !ah[2], ar);
      check("discharge_done", off >= DIS, dd);
   end
   initial begin
      void'($urandom(32'h89e5));
      repeat (12) @(posedge mclk_in);
      #1 rst_in = 0;
      repeat (40) i_host.drive($urandom % 2, $urandom % 2, $urandom % 8);
      // Second reset in mid-run, then the power-on hold again
      @(posedge mclk_in);
      #1 rst_in = 1;
      repeat (12) @(posedge mclk_in);
      #1 rst_in = 0;
      repeat (40) i_host.drive($urandom % 2, $urandom % 2, $urandom % 8);
      report_and_stop();
   end
endmodule // regulator_and_reset_control_tb_top
bind regulator_and_reset_control regulator_and_reset_control_asserts i_chk (
   .mclk_in(mclk_in),
   .rst_in(rst_in),
   .wlan_power_request_in(wlan_power_request_in),
   .apps_power_request_in(apps_power_request_in),
   .regulator_enable_out(regulator_enable_out),
   .wlan_reset_out(wlan_reset_out),
   .apps_reset_out(apps_reset_out),
   .device_reset_out(device_reset_out),
   .discharge_done_out(discharge_done_out)
);
